// ### src/gpio_port.sv
// Purpose: Four-bit bidirectional port with pullups, AHB-Lite slave
// Assumes: Single word transfers, one slave on the bus
// Notes: Zero-wait-state slave; response always OKAY
`timescale 1ns/100ps
`default_nettype none
module gpio_port
  import gpio_port_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [gpio_port_pkg::port_width-1:0] pin_in,
  output logic [gpio_port_pkg::port_width-1:0] pin_out,
  output logic [gpio_port_pkg::port_width-1:0] pin_oe_n,
  output logic [gpio_port_pkg::port_width-1:0] pullup_on,
  output logic [gpio_port_pkg::port_width-1:0] key_inputs,
  output logic [gpio_port_pkg::port_width-1:0] key_irq_enable_bits
);
  import gpio_port_pkg::*;

  // ==========================================================
  // Address decode
  function automatic logic decode_hit(input logic [31:0] addr);
    return (addr[31:addr_decode_msb+1] == '0) && (addr[1:0] == 2'h0);
  endfunction

  function automatic reg_sel_type decode_sel(input logic [31:0] addr);
    reg_sel_type sel;
    sel = sel_latch;
    if (addr[addr_decode_msb:0] == direction_offset[addr_decode_msb:0])
      sel = sel_direction;
    else if (addr[addr_decode_msb:0] == pullup_offset[addr_decode_msb:0])
      sel = sel_pullup;
    else if (addr[addr_decode_msb:0] == key_irq_offset[addr_decode_msb:0])
      sel = sel_key_irq;
    return sel;
  endfunction

  logic [port_width-1:0] port_a_latch;
  logic [port_width-1:0] port_a_direction;
  logic [port_width-1:0] port_a_pullup_enable;
  logic [port_width-1:0] key_irq_control;
  logic [port_width-1:0] pin_level;
  logic [port_width-1:0] drv_out;
  logic [port_width-1:0] drv_oe_n;
  logic [port_width-1:0] drv_pullup;
  logic dphase_write;
  reg_sel_type dphase_sel;
  logic addr_take;
  logic [31:0] next_hrdata;

  assign addr_take = hsel && hready && (htrans == htrans_nonseq) &&
                     decode_hit(haddr);

  // ==========================================================
  // Bus address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dphase_write <= 1'b0;
      dphase_sel <= sel_latch;
    end
    else if (hready)
    begin
      dphase_write <= addr_take && hwrite;
      dphase_sel <= decode_sel(haddr);
    end
  end

  // Never waits, never errors
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ==========================================================
  // Data latch, no reset so contents survive it
  always_ff @(posedge hclk)
  begin
    if (dphase_write && dphase_sel == sel_latch)
      port_a_latch <= hwdata[port_width-1:0];
  end

  // ==========================================================
  // Direction, pullup and keyboard enable registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      port_a_direction <= direction_reset;
    else if (dphase_write && dphase_sel == sel_direction)
      port_a_direction <= hwdata[port_width-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      port_a_pullup_enable <= pullup_reset;
    else if (dphase_write && dphase_sel == sel_pullup)
      port_a_pullup_enable <= hwdata[port_width-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      key_irq_control <= key_irq_reset;
    else if (dphase_write && dphase_sel == sel_key_irq)
      key_irq_control <= hwdata[port_width-1:0];
  end

  // ==========================================================
  // Pin path
  pin_level_sync u_sync
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .raw_level(pin_in),
    .synced_level(pin_level)
  );

  genvar gi;
  generate
    for (gi = 0; gi < port_width; gi++)
    begin : g_pin
      pin_driver u_drv
      (
        .hclk(hclk),
        .hresetn(hresetn),
        .latch_bit(port_a_latch[gi]),
        .direction_bit(port_a_direction[gi]),
        .pullup_bit(port_a_pullup_enable[gi]),
        .pin_out(drv_out[gi]),
        .pin_oe_n(drv_oe_n[gi]),
        .pullup_on(drv_pullup[gi])
      );
    end
  endgenerate

  assign pin_out = drv_out;
  assign pin_oe_n = drv_oe_n;
  assign pullup_on = drv_pullup;

  // Keyboard unit sees the pin level masked by its own enables, and the enables
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      key_inputs <= '0;
      key_irq_enable_bits <= key_irq_reset;
    end
    else
    begin
      key_inputs <= pin_level & key_irq_control;
      key_irq_enable_bits <= key_irq_control;
    end
  end

  // ==========================================================
  // Read mux; data answered combinationally-registered in address phase
  always_comb
  begin
    next_hrdata = read_zero;
    unique case (decode_sel(haddr))
      sel_latch:
        next_hrdata[port_width-1:0] =
          (port_a_direction & port_a_latch) |
          (~port_a_direction & pin_level);
      sel_direction:
        next_hrdata[port_width-1:0] = port_a_direction;
      sel_pullup:
        next_hrdata[port_width-1:0] = port_a_pullup_enable;
      sel_key_irq:
        next_hrdata[port_width-1:0] = key_irq_control;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= read_zero;
    else if (addr_take && !hwrite)
      hrdata <= next_hrdata;
  end

  // ==========================================================
  // Checks
  sequence dir_write_s;
    dphase_write && dphase_sel == sel_direction;
  endsequence

  sequence latch_write_s;
    dphase_write && dphase_sel == sel_latch;
  endsequence

  sequence pullup_write_s;
    dphase_write && dphase_sel == sel_pullup;
  endsequence

  sequence key_write_s;
    dphase_write && dphase_sel == sel_key_irq;
  endsequence

  sequence latch_read_s;
    addr_take && !hwrite && decode_sel(haddr) == sel_latch;
  endsequence

  sequence dir_read_s;
    addr_take && !hwrite && decode_sel(haddr) == sel_direction;
  endsequence

  dir_reset_zero_a: assert property (
    @(posedge hclk) $rose(hresetn) |-> port_a_direction == direction_reset)
    else $error("direction not cleared by reset");

  dir_write_take_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    dir_write_s |=> port_a_direction == $past(hwdata[port_width-1:0]))
    else $error("direction write lost");

  latch_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    latch_write_s |=> port_a_latch == $past(hwdata[port_width-1:0]))
    else $error("latch write lost");

  oe_follows_dir_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 pin_oe_n == ~$past(port_a_direction))
    else $error("output enable wrong");

  pullup_gate_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 pullup_on == ($past(port_a_pullup_enable) &
      ~$past(port_a_direction)))
    else $error("pullup state wrong");

  pullup_off_out_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 (pullup_on & $past(port_a_direction)) == '0)
    else $error("pullup on while output");

  read_out_pin_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    latch_read_s |=>
      (hrdata[port_width-1:0] & $past(port_a_direction)) ==
      ($past(port_a_latch) & $past(port_a_direction)))
    else $error("latch readback wrong");

  read_in_pin_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    latch_read_s |=>
      (hrdata[port_width-1:0] & ~$past(port_a_direction)) ==
      ($past(pin_level) & ~$past(port_a_direction)))
    else $error("pin readback wrong");

  key_route_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 key_inputs == ($past(pin_level) & $past(key_irq_control)))
    else $error("key input routing wrong");

  dir_readback_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    dir_read_s |=> hrdata[port_width-1:0] == $past(port_a_direction))
    else $error("direction readback wrong");

  pullup_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    pullup_write_s |=>
      port_a_pullup_enable == $past(hwdata[port_width-1:0]))
    else $error("pullup enable write lost");

  key_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    key_write_s |=> key_irq_control == $past(hwdata[port_width-1:0]))
    else $error("keyboard enable write lost");

  key_enable_copy_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 key_irq_enable_bits == $past(key_irq_control))
    else $error("keyboard enable copy wrong");

  // Sampled reset gates the start, the sync flops restart at release
  pin_sync_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresetn |-> ##2 pin_level == $past(pin_in, 2))
    else $error("pin level not synchronised");

  pad_drive_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    |port_a_direction |=> pin_out == $past(port_a_latch))
    else $error("pad value differs from latch");
endmodule
`default_nettype wire

// ### src/gpio_port_pkg.sv
// Purpose: Shared constants for the four-bit port with pullups
// Assumes: 32-bit AHB-Lite register bus, word-aligned registers
// Notes: Offsets other than the latch register are local choices
package gpio_port_pkg;
  localparam int port_width = 4;
  localparam logic [31:0] latch_offset = 32'h0000_0000;
  localparam logic [31:0] direction_offset = 32'h0000_0004;
  localparam logic [31:0] pullup_offset = 32'h0000_0008;
  localparam logic [31:0] key_irq_offset = 32'h0000_000c;
  localparam logic [3:0] direction_reset = 4'h0;
  localparam logic [3:0] pullup_reset = 4'h0;
  localparam logic [3:0] key_irq_reset = 4'h0;
  localparam logic [3:0] addr_decode_msb = 4'h3;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;
  localparam logic [31:0] read_zero = 32'h0000_0000;
  typedef enum logic [1:0]
  {
    sel_latch = 2'h0,
    sel_direction = 2'h1,
    sel_pullup = 2'h3,
    sel_key_irq = 2'h2
  } reg_sel_type;
endpackage

// ### src/pin_level_sync.sv
// Purpose: Two-flop synchroniser for the four pin levels
// Assumes: Pins are asynchronous to hclk
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module pin_level_sync
  import gpio_port_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [gpio_port_pkg::port_width-1:0] raw_level,
  output logic [gpio_port_pkg::port_width-1:0] synced_level
);
  logic [port_width-1:0] first_stage;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      first_stage <= '0;
      synced_level <= '0;
    end
    else
    begin
      first_stage <= raw_level;
      synced_level <= first_stage;
    end
  end
endmodule
`default_nettype wire

// ### src/pin_driver.sv
// Purpose: Per-pin output enable and pullup gating
// Assumes: Direction 1 means output
// Notes: Outputs are registered for clean pad control
`timescale 1ns/100ps
`default_nettype none
module pin_driver
  import gpio_port_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic latch_bit,
  input wire logic direction_bit,
  input wire logic pullup_bit,
  output logic pin_out,
  output logic pin_oe_n,
  output logic pullup_on
);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
      pullup_on <= 1'b0;
    end
    else
    begin
      pin_out <= latch_bit;
      pin_oe_n <= ~direction_bit;
      // Output mode forces the pullup off
      pullup_on <= pullup_bit & ~direction_bit;
    end
  end
endmodule
`default_nettype wire

// ### tb/board_pins.sv
// Purpose: Board-side model of the four port pins
// Assumes: Pin level resolves from pad enable, board drive, pullup
// Notes: Undriven pins toggle, so a stale level never reads as valid
`timescale 1ns/100ps
`default_nettype none
module board_pins
  import gpio_port_pkg::*;
(
  input wire logic hclk,
  input wire logic [gpio_port_pkg::port_width-1:0] pin_out,
  input wire logic [gpio_port_pkg::port_width-1:0] pin_oe_n,
  input wire logic [gpio_port_pkg::port_width-1:0] pullup_on,
  input wire logic [gpio_port_pkg::port_width-1:0] ext_val,
  input wire logic [gpio_port_pkg::port_width-1:0] ext_en,
  output logic [gpio_port_pkg::port_width-1:0] pin_level
);
  logic [port_width-1:0] float_val = 4'h5;
  always @(posedge hclk)
    float_val <= ~float_val;
  always_comb
  begin
    for (int i = 0; i < port_width; i++)
      if (!pin_oe_n[i])
        pin_level[i] = pin_out[i];
      else if (ext_en[i])
        pin_level[i] = ext_val[i];
      else if (pullup_on[i])
        pin_level[i] = 1'b1;
      else
        pin_level[i] = float_val[i];
  end
endmodule
`default_nettype wire

// ### tb/tb_four_bit_gpio_port_with_pullups.sv
// Purpose: Self-checking bench for the four-bit port
// Assumes: Zero-wait AHB-Lite slave, board model on the pins
// Notes: Reset values and register rows first, then pin and mid-run reset cases
`timescale 1ns/100ps
`default_nettype none
module tb_four_bit_gpio_port_with_pullups;
  import gpio_port_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp;
  logic [3:0] pin_in, pin_out, pin_oe_n, pullup_on, key_in, key_en;
  logic [3:0] ext_val = 4'h0;
  logic [3:0] ext_en = 4'h0;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] rows [4][3] = '{'{32'h4, 32'h5, 32'h5},
    '{32'h8, 32'ha, 32'ha}, '{32'hc, 32'h3, 32'h3},
    '{32'h4, 32'hffff_fff0, 32'h0}};
  always #5 hclk = ~hclk;
  gpio_port u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize_word),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_on(pullup_on),
    .key_inputs(key_in), .key_irq_enable_bits(key_en));
  board_pins u_board (.hclk(hclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pullup_on(pullup_on), .ext_val(ext_val), .ext_en(ext_en),
    .pin_level(pin_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Address phase held until hready, then data phase until hready
  task automatic xfer(input logic [31:0] a, input logic w,
    input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= htrans_nonseq;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    chk(pin_oe_n, 4'hf);
    xfer(direction_offset, 1'b0, 32'h0);
    chk(rd, 32'h0);
    xfer(pullup_offset, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 32'h0);
    $display("reset values done");
    // Latch loaded before any pin turns output
    xfer(latch_offset, 1'b1, 32'h0);
    foreach (rows[i])
    begin
      xfer(rows[i][0], 1'b1, rows[i][1]);
      xfer(rows[i][0], 1'b0, 32'h0);
      chk(rd, rows[i][2]);
    end
    xfer(32'h10, 1'b1, 32'hf);
    xfer(direction_offset, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("register rows done");
    xfer(pullup_offset, 1'b1, 32'hf);
    repeat (2) @(posedge hclk);
    chk(pullup_on, 4'hf);
    xfer(latch_offset, 1'b0, 32'h0);
    chk(rd, 32'hf);
    ext_en <= 4'hf;
    ext_val <= 4'h6;
    xfer(latch_offset, 1'b1, 32'h9);
    repeat (4) @(posedge hclk);
    xfer(latch_offset, 1'b0, 32'h0);
    chk(rd, 32'h6);
    xfer(key_irq_offset, 1'b1, 32'h5);
    repeat (4) @(posedge hclk);
    chk(key_in, 4'h4);
    chk(key_en, 4'h5);
    $display("input pins done");
    ext_en <= 4'h0;
    xfer(direction_offset, 1'b1, 32'hf);
    repeat (2) @(posedge hclk);
    chk(pin_oe_n, 4'h0);
    chk(pin_out, 4'h9);
    chk(pullup_on, 4'h0);
    xfer(latch_offset, 1'b0, 32'h0);
    chk(rd, 32'h9);
    // Unmapped write must not alias onto the latch
    xfer(32'h10, 1'b1, 32'h6);
    xfer(latch_offset, 1'b0, 32'h0);
    chk(rd, 32'h9);
    chk(hresp, 32'h0);
    $display("output pins done");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(direction_offset, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk(pin_oe_n, 4'hf);
    xfer(direction_offset, 1'b1, 32'hf);
    xfer(latch_offset, 1'b0, 32'h0);
    chk(rd, 32'h9);
    $display("mid-run reset done");
    conclude();
  end
endmodule
`default_nettype wire
